// ### hw/cest_error_state.sv
// How it works
// RULE1 - Transmitter bus-passive, status bit 4, is set while transmit errors exceed 127.
// RULE2 - Transmitter warning, status bit 2, is set while transmit errors exceed 95.
// RULE3 - Combined warning, status bit 0, is receiver warning OR transmitter warning.
// RULE4 - Buffer control: read-only abort, lost, error; writable request, priority; reset 0.
// RULE5 - Setting request starts sending, clears flags; engine clears on success; clearing aborts.
// RULE6 - Engine results set abort, lost-arbitration and bus-error flags of the buffer.
// RULE7 - Pending buffers are chosen by priority, 11 highest, identifier untouched.
// RULE8 - Status flags follow error counters combinationally, always consistent with them.
module cest_error_state
  import cest_pkg::*;
#(
  parameter int NUM_BUFFERS = 3
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic [3:0]             regAddr,
  input  wire logic [7:0]             regWriteData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [7:0]             regReadData,
  input  wire logic [7:0]             txErrorCount,
  input  wire logic [7:0]             rxErrorCount,
  input  wire cest_tx_result_t        txResult,
  output logic                        txPending,
  output logic      [1:0]             txSelected,
  output logic      [NUM_BUFFERS-1:0] txAbortRequest
);

  // ---------------------------------------------------------------
  // Error state flags
  // ---------------------------------------------------------------
  wire logic txBusPassive = txErrorCount > PASSIVE_LIMIT;  // RULE1 RULE8
  wire logic rxBusPassive = rxErrorCount > PASSIVE_LIMIT;
  wire logic txWarning    = txErrorCount > WARN_LIMIT;     // RULE2 RULE8
  wire logic rxWarning    = rxErrorCount > WARN_LIMIT;
  wire logic errorWarning = txWarning | rxWarning;         // RULE3

  wire logic [7:0] commStatus = {3'h0, txBusPassive, rxBusPassive,
                                 txWarning, rxWarning, errorWarning};

  // ---------------------------------------------------------------
  // Transmit buffer control registers
  // ---------------------------------------------------------------
  cest_txb_ctrl_t ctrl     [NUM_BUFFERS];
  logic [7:0]     ctrlByte [NUM_BUFFERS];
  logic [NUM_BUFFERS-1:0] bufWrite;
  logic [NUM_BUFFERS-1:0] bufHit;

  genvar g;
  generate
    for (g = 0; g < NUM_BUFFERS; g++) begin : g_buf
      wire logic [3:0] myAddr = ADDR_TXB_CTRL0 + 4'(g);
      wire logic resultHere = txResult.valid && (txResult.buffer == 2'(g));
      wire logic newRequest = regWriteData[BIT_REQUEST];
      assign bufHit[g]   = regAddr == myAddr;
      assign bufWrite[g] = regWrite && bufHit[g];
      // Clearing a set request asks the engine to abort it
      assign txAbortRequest[g] = bufWrite[g] && ctrl[g].request && !newRequest;  // RULE5
      assign ctrlByte[g] = {1'b0, ctrl[g].aborted, ctrl[g].lostArb, ctrl[g].busErr,
                            ctrl[g].request, 1'b0, ctrl[g].prio};  // RULE4

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          ctrl[g] <= '0;  // RULE4
        end else begin
          if (bufWrite[g]) begin
            ctrl[g].prio     <= regWriteData[BIT_PRI_HI:BIT_PRI_LO];
            ctrl[g].request  <= newRequest;
            if (newRequest) begin
              ctrl[g].aborted <= 1'b0;  // RULE5
              ctrl[g].lostArb <= 1'b0;
              ctrl[g].busErr  <= 1'b0;
            end
          end
          // Engine results come after the write so the engine wins over a register write in the same cycle
          if (resultHere) begin
            if (txResult.aborted) ctrl[g].aborted <= 1'b1;  // RULE6
            if (txResult.lostArb) ctrl[g].lostArb <= 1'b1;  // RULE6
            if (txResult.busErr)  ctrl[g].busErr  <= 1'b1;  // RULE6
            if (txResult.sent || txResult.aborted) ctrl[g].request <= 1'b0;  // RULE5
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Priority selection: highest field wins, lowest index on a tie
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0] best;
    best       = 3'h0;
    txPending  = 1'b0;
    txSelected = 2'h0;
    for (int i = 0; i < NUM_BUFFERS; i++) begin
      if (ctrl[i].request && ({1'b1, ctrl[i].prio} > best)) begin  // RULE7
        best       = {1'b1, ctrl[i].prio};
        txPending  = 1'b1;
        txSelected = 2'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [7:0] bufReadData;
  always_comb begin
    bufReadData = 8'h00;
    for (int i = 0; i < NUM_BUFFERS; i++) begin
      if (bufHit[i]) bufReadData = ctrlByte[i];
    end
  end

  wire logic [7:0] next_regReadData =
      !regRead                      ? 8'h00 :
      (regAddr == ADDR_COMM_STATUS) ? commStatus :
      (regAddr == ADDR_SELECTION)   ? {5'h00, txPending, txSelected} :
                                      bufReadData;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) regReadData <= 8'h00;
    else          regReadData <= next_regReadData;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_tx_passive;
    @(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr == ADDR_COMM_STATUS
      |=> regReadData[BIT_TX_PASSIVE] == ($past(txErrorCount) > 8'h7f);
  endproperty
  a_tx_passive: assert property (p_tx_passive) else $error("bus-passive bit wrong");  // RULE1

  property p_tx_warn;
    @(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr == ADDR_COMM_STATUS
      |=> regReadData[BIT_TX_WARN] == ($past(txErrorCount) > 8'h5f);
  endproperty
  a_tx_warn: assert property (p_tx_warn) else $error("tx warning bit wrong");  // RULE2

  property p_combined_error_warning;
    @(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr == ADDR_COMM_STATUS |=> regReadData[BIT_COMBINED_ERROR_WARNING] ==
      ($past(txErrorCount) > 8'h5f || $past(rxErrorCount) > 8'h5f);
  endproperty
  a_combined_error_warning: assert property (p_combined_error_warning) else $error("combined warning wrong");  // RULE3

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    regRead && bufHit[0] |=> regReadData[7] == 1'b0 && regReadData[2] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");  // RULE4

  property p_request_clears;
    @(posedge ref_clk) disable iff (!reset_n)
    bufWrite[0] && regWriteData[BIT_REQUEST] && !txResult.valid
      |=> ctrl[0].request && !ctrl[0].aborted && !ctrl[0].lostArb && !ctrl[0].busErr;
  endproperty
  a_request_clears: assert property (p_request_clears) else $error("request set failed");  // RULE5

  property p_sent_clears;
    @(posedge ref_clk) disable iff (!reset_n)
    txResult.valid && txResult.sent && txResult.buffer == 2'h0 |=> !ctrl[0].request;
  endproperty
  a_sent_clears: assert property (p_sent_clears) else $error("request not cleared");  // RULE5

  property p_lost_arb;
    @(posedge ref_clk) disable iff (!reset_n)
    txResult.valid && txResult.lostArb && txResult.buffer == 2'h0 |=> ctrl[0].lostArb;
  endproperty
  a_lost_arb: assert property (p_lost_arb) else $error("lost-arbitration not set");  // RULE6

  property p_priority;
    @(posedge ref_clk) disable iff (!reset_n)
    txPending && ctrl[0].request |-> ctrl[txSelected].prio >= ctrl[0].prio;
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority chosen");  // RULE7

  property p_passive_live;
    @(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr == ADDR_COMM_STATUS
      |=> regReadData[BIT_RX_PASSIVE] == ($past(rxErrorCount) > 8'h7f)
          && regReadData[BIT_RX_WARN] == ($past(rxErrorCount) > 8'h5f);
  endproperty
  a_passive_live: assert property (p_passive_live) else $error("flag lags counter");  // RULE8

  // The status-flag checks below watch the last buffer, where the bench exercises the status flags; the abort and priority-write checks below watch buffer 0
  localparam int LAST_BUF = NUM_BUFFERS - 1;

  property p_abort_done;
    @(posedge ref_clk) disable iff (!reset_n)
    txAbortRequest[0] |=> !ctrl[0].request;
  endproperty
  a_abort_done: assert property (p_abort_done) else $error("request kept after abort");  // RULE5

  property p_status_kept;
    @(posedge ref_clk) disable iff (!reset_n)
    bufWrite[LAST_BUF] && !regWriteData[BIT_REQUEST] && !txResult.valid
      |=> $stable(ctrl[LAST_BUF].aborted) && $stable(ctrl[LAST_BUF].lostArb)
          && $stable(ctrl[LAST_BUF].busErr);
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("read-only flag written");  // RULE4

  property p_prio_write;
    @(posedge ref_clk) disable iff (!reset_n)
    bufWrite[0] |=> ctrl[0].prio == $past(regWriteData[BIT_PRI_HI:BIT_PRI_LO]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority not stored");  // RULE4

  property p_bus_err;
    @(posedge ref_clk) disable iff (!reset_n)
    txResult.valid && txResult.busErr && txResult.buffer == 2'(LAST_BUF)
      |=> ctrl[LAST_BUF].busErr;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus-error flag not set");  // RULE6

  property p_aborted;
    @(posedge ref_clk) disable iff (!reset_n)
    txResult.valid && txResult.aborted && txResult.buffer == 2'(LAST_BUF)
      |=> ctrl[LAST_BUF].aborted && !ctrl[LAST_BUF].request;
  endproperty
  a_aborted: assert property (p_aborted) else $error("abort flag not set");  // RULE6

  property p_selected_pending;
    @(posedge ref_clk) disable iff (!reset_n)
    txPending |-> ctrl[txSelected].request;
  endproperty
  a_selected_pending: assert property (p_selected_pending) else $error("idle buffer chosen");  // RULE7

  c_passive:  cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(txBusPassive));
  c_abort:    cover property (@(posedge ref_clk) disable iff (!reset_n) |txAbortRequest);
  c_sent:     cover property (@(posedge ref_clk) disable iff (!reset_n)
                              txResult.valid && txResult.sent);
  c_two_pend: cover property (@(posedge ref_clk) disable iff (!reset_n)
                              ctrl[0].request && ctrl[1].request);
  c_bus_err:  cover property (@(posedge ref_clk) disable iff (!reset_n)
                              txResult.valid && txResult.busErr);

endmodule : cest_error_state

// ### hw/cest_pkg.sv
package cest_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_COMM_STATUS = 4'h0;
  localparam logic [3:0] ADDR_TXB_CTRL0   = 4'h1;  // Buffers follow at 1, 2, 3, ...
  localparam logic [3:0] ADDR_SELECTION   = 4'h8;

  // ---------------------------------------------------------------
  // Communication status fields
  // ---------------------------------------------------------------
  localparam int BIT_TX_PASSIVE = 4;
  localparam int BIT_RX_PASSIVE = 3;
  localparam int BIT_TX_WARN    = 2;
  localparam int BIT_RX_WARN    = 1;
  localparam int BIT_COMBINED_ERROR_WARNING      = 0;

  localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;  // 127
  localparam logic [7:0] WARN_LIMIT    = 8'h5f;  // 95

  // ---------------------------------------------------------------
  // Transmit buffer control fields
  // ---------------------------------------------------------------
  localparam int BIT_ABORTED  = 6;
  localparam int BIT_LOST_ARB = 5;
  localparam int BIT_BUS_ERR  = 4;
  localparam int BIT_REQUEST  = 3;
  localparam int BIT_PRI_HI   = 1;
  localparam int BIT_PRI_LO   = 0;

  localparam logic [7:0] TXB_CTRL_RESET = 8'h00;

  typedef struct packed {
    logic       aborted;
    logic       lostArb;
    logic       busErr;
    logic       request;
    logic [1:0] prio;
  } cest_txb_ctrl_t;

  // Outcome of one transmission, reported by the protocol engine
  typedef struct packed {
    logic       valid;
    logic [1:0] buffer;
    logic       sent;
    logic       aborted;
    logic       lostArb;
    logic       busErr;
  } cest_tx_result_t;

endpackage : cest_pkg

// ### tb/cest_engine_model.sv
module cest_engine_model
  import cest_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            txPending,
  input  wire logic [1:0]      txSelected,
  output cest_tx_result_t      txResult,
  output logic      [7:0]      txErrorCount,
  output logic      [7:0]      rxErrorCount
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    txResult = '0;
    txErrorCount = 8'h00;
    rxErrorCount = 8'h00;
  end
  task automatic counts(input logic [7:0] tx, input logic [7:0] rx);
    @(posedge ref_clk);
    txErrorCount <= tx;
    rxErrorCount <= rx;
  endtask : counts
  // Kind is {sent, aborted, lostArb, busErr}; the engine only reports on a pending buffer
  task automatic report(input logic [3:0] kind);
    @(posedge ref_clk);
    txResult <= {txPending, txSelected, kind};
    @(posedge ref_clk);
    txResult <= '0;
  endtask : report
endmodule : cest_engine_model

// ### tb/tb_top.sv
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
  import cest_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, txPending;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00, regReadData, txErrorCount, rxErrorCount;
  logic [1:0] txSelected;
  logic [2:0] txAbortRequest;
  cest_tx_result_t txResult;
  int num_errors = 0, compares = 0;
  cest_error_state #(.NUM_BUFFERS(3)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .txErrorCount(txErrorCount), .rxErrorCount(rxErrorCount),
    .txResult(txResult), .txPending(txPending), .txSelected(txSelected),
    .txAbortRequest(txAbortRequest));
  cest_engine_model i_eng (.ref_clk(ref_clk), .txPending(txPending), .txSelected(txSelected),
    .txResult(txResult), .txErrorCount(txErrorCount), .rxErrorCount(rxErrorCount));
  initial forever #2.5 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  // Abort pulse is combinational, so it is looked at inside the strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [2:0] ab);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    #1 `CHK(txAbortRequest, ab)
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 `CHK(regReadData, exp)
  endtask : rd
  function automatic logic [7:0] status(input logic [7:0] t, input logic [7:0] r);
    status = {3'h0, t > 8'h7f, r > 8'h7f, t > 8'h5f, r > 8'h5f, (t > 8'h5f) | (r > 8'h5f)};
  endfunction : status
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    rd(4'h0, 8'h00);
    for (int i = 1; i < 4; i++) rd(i[3:0], 8'h00);
    rd(4'h9, 8'h00);
    rd(4'h8, 8'h00);
    `CHK(txPending, 1'b0)
  endtask : test_reset
  task automatic test_status;
    logic [7:0] tv [5] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff};
    logic [7:0] rv [5] = '{8'h60, 8'h5f, 8'h80, 8'h00, 8'h7f};
    for (int i = 0; i < 5; i++) begin
      i_eng.counts(tv[i], rv[i]);
      rd(4'h0, status(tv[i], rv[i]));
    end
    wr(4'h0, 8'hff, 3'h0);
    rd(4'h0, status(8'hff, 8'h7f));
  endtask : test_status
  task automatic test_control;
    wr(4'h1, 8'hff, 3'h0);
    rd(4'h1, 8'h0b);
    wr(4'h1, 8'h00, 3'h1);
    rd(4'h1, 8'h00);
  endtask : test_control
  task automatic test_priority;
    wr(4'h1, 8'h09, 3'h0);
    wr(4'h2, 8'h0b, 3'h0);
    wr(4'h3, 8'h0b, 3'h0);
    rd(4'h8, 8'h05);
    `CHK(txSelected, 2'h1)
    `CHK(txPending, 1'b1)
    i_eng.report(4'h8);
    rd(4'h2, 8'h03);
    rd(4'h8, 8'h06);
    i_eng.report(4'h4);
    rd(4'h3, 8'h43);
    wr(4'h3, 8'h0b, 3'h0);
    rd(4'h3, 8'h0b);
    i_eng.report(4'h1);
    rd(4'h3, 8'h1b);
    i_eng.report(4'h2);
    rd(4'h3, 8'h3b);
    wr(4'h3, 8'h03, 3'h4);
    rd(4'h8, 8'h04);
    `CHK(txSelected, 2'h0)
  endtask : test_priority
  task automatic close_out;
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    test_reset();
    test_status();
    test_control();
    test_priority();
    close_out();
  end
  // Whole run is about 76 cycles; about twenty times that (1500 cycles) before giving up
  initial begin
    #7500;
    num_errors++;
    close_out();
  end
endmodule : tb_top
